// ---- hdl/hfo_pkg.sv ----
// Package for the high-frequency oscillator control block.
// Assumes APB with 32-bit data; register index times four is the byte address.
package hfo_pkg;

  // Register indices and byte addresses
  localparam logic [9:0]  IDX_OSC_CTRL    = 10'h0a9;
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h0aa;
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h0ab;
  localparam logic [9:0]  IDX_EXT_OSC     = 10'h0b5;
  localparam logic [11:0] ADDR_OSC_CTRL   = {IDX_OSC_CTRL, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] ADDR_EXT_OSC    = {IDX_EXT_OSC, 2'b00};

  // Control and external oscillator register field positions
  localparam int BIT_ENABLE  = 7;
  localparam int BIT_READY   = 6;
  localparam int BIT_SUSPEND = 5;
  localparam int BIT_SYNC    = 4;
  localparam int BIT_SS      = 3;
  localparam int BIT_UNUSED  = 2;
  localparam int DIV_LSB     = 0;
  localparam int EXT_MODE_LSB = 4;

  // Interrupt status bit positions
  localparam int IRQ_READY = 0;
  localparam int IRQ_WAKE  = 1;
  localparam int IRQ_SYNC  = 2;

  // Reset values
  localparam logic [7:0] RST_OSC_CTRL = 8'hc0;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;
  localparam logic [2:0] RST_EXT_MODE = 3'h0;

  // Timer clocks of sync busy after a foreign wake-up
  localparam logic [1:0] SYNC_TIMER_CLOCKS = 2'h3;

  // External oscillator modes
  localparam logic [2:0] EXT_CMOS     = 3'h2;
  localparam logic [2:0] EXT_CMOS_DIV = 3'h3;
  localparam logic [2:0] EXT_RC       = 3'h4;
  localparam logic [2:0] EXT_CAP      = 3'h5;
  localparam logic [2:0] EXT_XTAL     = 3'h6;
  localparam logic [2:0] EXT_XTAL_DIV = 3'h7;

  typedef struct packed {
    logic       enable;
    logic       suspend;
    logic       ss_enable;
    logic [1:0] divide_select;
  } hfo_ctrl_t;

  typedef struct packed {
    logic crystal_input_claim;
    logic crystal_output_claim;
  } hfo_pins_t;

  typedef enum logic [1:0] {
    HFO_RUN,
    HFO_SUSPENDED,
    HFO_OFF
  } hfo_state_t;

endpackage : hfo_pkg

// ---- hdl/hfo_post_divider.sv ----
// Post-scaling divider: one-cycle system clock enable every 8, 4, 2 or 1 cycles.
// Assumes the oscillator is modelled by pclk and run is a same-domain level.
`timescale 1ns/1ps
module hfo_post_divider (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] divide_select,
  // Output
  output logic            clk_enable
);

  logic [2:0] count;
  logic [2:0] next_count;
  logic       next_clk_enable;
  logic [2:0] last;

  // Code to terminal count
  function automatic logic [2:0] div_last(input logic [1:0] code);
    case (code)
      2'b00:   div_last = 3'h7;
      2'b01:   div_last = 3'h3;
      2'b10:   div_last = 3'h1;
      default: div_last = 3'h0;
    endcase
  endfunction : div_last

  always_comb begin
    last            = div_last(divide_select);
    next_count      = count;
    next_clk_enable = 1'b0;
    if (!run) begin
      next_count = 3'h0;
    end else if (count >= last) begin
      next_count      = 3'h0;
      next_clk_enable = 1'b1;
    end else begin
      next_count = count + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count      <= 3'h0;
      clk_enable <= 1'b0;
    end else begin
      count      <= next_count;
      clk_enable <= next_clk_enable;
    end
  end

  property p_div_by_one;
    @(posedge pclk) disable iff (!presetn)
    $past(run) && $past(divide_select) == 2'b11 |-> clk_enable;
  endproperty
  a_div_by_one: assert property (p_div_by_one) else $error("Divide by 1 missed pulse");

  // Pulse only on the eighth count while the code stays at divide by 8
  property p_div_by_eight;
    @(posedge pclk) disable iff (!presetn)
    run && divide_select == 2'b00 |=> clk_enable == ($past(count) == 3'h7);
  endproperty
  a_div_by_eight: assert property (p_div_by_eight) else $error("Divide by 8 pulse wrong");

  c_div_eight: cover property (@(posedge pclk) disable iff (!presetn)
    clk_enable && divide_select == 2'b00);

endmodule : hfo_post_divider

// ---- hdl/hfo_control.sv ----
// High-frequency oscillator control with APB register access.
// Assumes pins are asynchronous; wake and timer inputs come from pins.
`timescale 1ns/1ps
module hfo_control (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Oscillator and wake pins
  input  wire logic        osc_at_freq,
  input  wire logic        wake_event,
  input  wire logic        wake_by_timer,
  input  wire logic        timer_clk,
  // Oscillator controls
  output logic             hf_osc_run,
  output logic             spread_spectrum_enable,
  output logic             system_clock_en,
  output hfo_pkg::hfo_pins_t pin_claim,
  // Interrupt
  output logic             irq
);

  // Synchronisers for pins
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       timer_prev;
  logic       at_freq_s;
  logic       wake_s;
  logic       wake_timer_s;
  logic       timer_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a     <= 4'h0;
      sync_b     <= 4'h0;
      timer_prev <= 1'b0;
    end else begin
      sync_a     <= {osc_at_freq, wake_event, wake_by_timer, timer_clk};
      sync_b     <= sync_a;
      timer_prev <= sync_b[0];
    end
  end

  assign at_freq_s    = sync_b[3];
  assign wake_s       = sync_b[2];
  assign wake_timer_s = sync_b[1];
  assign timer_s      = sync_b[0];

  // Register state
  hfo_pkg::hfo_ctrl_t ctrl;
  hfo_pkg::hfo_ctrl_t next_ctrl;
  hfo_pkg::hfo_state_t state;
  hfo_pkg::hfo_state_t next_state;
  logic [1:0]  sync_cnt;
  logic [1:0]  next_sync_cnt;
  logic [2:0]  irq_status;
  logic [2:0]  next_irq_status;
  logic [2:0]  irq_mask;
  logic [2:0]  next_irq_mask;
  logic [2:0]  ext_mode;
  logic [2:0]  next_ext_mode;
  logic        ready;
  logic        next_ready;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_run;
  logic        wr;
  logic        wake_hit;
  logic        tick;
  logic [7:0]  ctrl_byte;
  hfo_pkg::hfo_pins_t next_claim;

  // Address decode shared by read and write
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      hfo_pkg::ADDR_OSC_CTRL:   reg_sel = 2'h0;
      hfo_pkg::ADDR_IRQ_STATUS: reg_sel = 2'h1;
      hfo_pkg::ADDR_IRQ_MASK:   reg_sel = 2'h2;
      default:                  reg_sel = 2'h3;
    endcase
  endfunction : reg_sel

  function automatic logic mapped(input logic [11:0] a);
    mapped = (reg_sel(a) != 2'h3) || (a == hfo_pkg::ADDR_EXT_OSC);
  endfunction : mapped

  assign wr       = psel && penable && pready && pwrite;
  assign tick     = timer_s && !timer_prev;
  assign wake_hit = state == hfo_pkg::HFO_SUSPENDED && (wake_s || wake_timer_s);
  assign ctrl_byte = {ctrl.enable, ready, ctrl.suspend, (sync_cnt != 2'h0),
                      ctrl.ss_enable, 1'b0, ctrl.divide_select};

  // Control register and oscillator state
  always_comb begin
    next_ctrl     = ctrl;
    next_state    = state;
    next_sync_cnt = sync_cnt;
    if (wr && reg_sel(paddr) == 2'h0) begin
      next_ctrl.enable        = pwdata[hfo_pkg::BIT_ENABLE];
      next_ctrl.ss_enable     = pwdata[hfo_pkg::BIT_SS];
      next_ctrl.divide_select = pwdata[hfo_pkg::DIV_LSB +: 2];
      if (pwdata[hfo_pkg::BIT_SUSPEND]) begin
        next_ctrl.suspend = 1'b1;
      end
    end
    if (tick && sync_cnt != 2'h0) begin
      next_sync_cnt = sync_cnt - 2'h1;
    end
    case (state)
      hfo_pkg::HFO_RUN: begin
        if (!ctrl.enable) begin
          next_state = hfo_pkg::HFO_OFF;
        end else if (ctrl.suspend) begin
          next_state = hfo_pkg::HFO_SUSPENDED;
        end
      end
      hfo_pkg::HFO_SUSPENDED: begin
        if (wake_hit) begin
          next_state        = hfo_pkg::HFO_RUN;
          next_ctrl.suspend = 1'b0;
          if (!wake_timer_s) begin
            next_sync_cnt = hfo_pkg::SYNC_TIMER_CLOCKS;
          end
        end else if (!ctrl.enable) begin
          next_state = hfo_pkg::HFO_OFF;
        end
      end
      hfo_pkg::HFO_OFF: begin
        if (ctrl.enable) begin
          next_state = hfo_pkg::HFO_RUN;
        end
      end
      default: next_state = hfo_pkg::HFO_OFF;
    endcase
    next_run   = next_ctrl.enable && !next_ctrl.suspend;
    next_ready = next_run && state == hfo_pkg::HFO_RUN && at_freq_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= hfo_pkg::hfo_ctrl_t'({hfo_pkg::RST_OSC_CTRL[7], hfo_pkg::RST_OSC_CTRL[5],
                                          hfo_pkg::RST_OSC_CTRL[3], hfo_pkg::RST_OSC_CTRL[1:0]});
      state      <= hfo_pkg::HFO_RUN;
      sync_cnt   <= 2'h0;
      ready      <= hfo_pkg::RST_OSC_CTRL[6];
      hf_osc_run <= hfo_pkg::RST_OSC_CTRL[7];
      spread_spectrum_enable <= hfo_pkg::RST_OSC_CTRL[3];
    end else begin
      ctrl       <= next_ctrl;
      state      <= next_state;
      sync_cnt   <= next_sync_cnt;
      ready      <= next_ready;
      hf_osc_run <= next_run;
      spread_spectrum_enable <= next_ctrl.ss_enable;
    end
  end

  // External mode and pin claims
  always_comb begin
    next_ext_mode = ext_mode;
    if (wr && paddr == hfo_pkg::ADDR_EXT_OSC) begin
      next_ext_mode = pwdata[hfo_pkg::EXT_MODE_LSB +: 3];
    end
    next_claim = '0;
    case (next_ext_mode)
      hfo_pkg::EXT_XTAL, hfo_pkg::EXT_XTAL_DIV: begin
        next_claim = '{crystal_input_claim: 1'b1, crystal_output_claim: 1'b1};
      end
      hfo_pkg::EXT_CMOS, hfo_pkg::EXT_CMOS_DIV, hfo_pkg::EXT_RC, hfo_pkg::EXT_CAP: begin
        next_claim.crystal_output_claim = 1'b1;
      end
      default: next_claim = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode  <= hfo_pkg::RST_EXT_MODE;
      pin_claim <= '0;
    end else begin
      ext_mode  <= next_ext_mode;
      pin_claim <= next_claim;
    end
  end

  // Interrupts: sticky, write one to clear, set wins
  always_comb begin
    next_irq_status = irq_status;
    next_irq_mask   = irq_mask;
    if (wr && reg_sel(paddr) == 2'h1) begin
      next_irq_status = irq_status & ~pwdata[2:0];
    end
    if (wr && reg_sel(paddr) == 2'h2) begin
      next_irq_mask = pwdata[2:0];
    end
    next_irq_status[hfo_pkg::IRQ_READY] = next_irq_status[hfo_pkg::IRQ_READY] | (next_ready && !ready);
    next_irq_status[hfo_pkg::IRQ_WAKE]  = next_irq_status[hfo_pkg::IRQ_WAKE] | wake_hit;
    next_irq_status[hfo_pkg::IRQ_SYNC]  = next_irq_status[hfo_pkg::IRQ_SYNC]
                                          | (sync_cnt != 2'h0 && next_sync_cnt == 2'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'h0;
      irq_mask   <= hfo_pkg::RST_IRQ_MASK;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq        <= |(next_irq_status & next_irq_mask);
    end
  end

  // APB answer: ready in the first access cycle
  always_comb begin
    next_pready  = psel && !penable;
    next_pslverr = psel && !penable && !mapped(paddr);
    next_prdata  = 32'h0;
    if (psel && !penable) begin
      case (reg_sel(paddr))
        2'h0:    next_prdata = {24'h0, ctrl_byte};
        2'h1:    next_prdata = {29'h0, irq_status};
        2'h2:    next_prdata = {29'h0, irq_mask};
        default: next_prdata = (paddr == hfo_pkg::ADDR_EXT_OSC) ? {25'h0, ext_mode, 4'h0} : 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Post-scaling divider
  hfo_post_divider u_div (
    .pclk          (pclk),
    .presetn       (presetn),
    .run           (hf_osc_run),
    .divide_select (ctrl.divide_select),
    .clk_enable    (system_clock_en)
  );

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_enable_off;
    wr && paddr == hfo_pkg::ADDR_OSC_CTRL && !pwdata[hfo_pkg::BIT_ENABLE] |=> !hf_osc_run;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("Oscillator ran after disable");

  property p_ready_needs_run;
    ready |-> hf_osc_run && state == hfo_pkg::HFO_RUN;
  endproperty
  a_ready_needs_run: assert property (p_ready_needs_run) else $error("Ready while stopped");

  property p_suspend_entry;
    wr && paddr == hfo_pkg::ADDR_OSC_CTRL && pwdata[hfo_pkg::BIT_SUSPEND] && !wake_hit
      |=> ctrl.suspend && !hf_osc_run;
  endproperty
  a_suspend_entry: assert property (p_suspend_entry) else $error("Suspend not entered");

  property p_wake_resume;
    wake_hit |=> !ctrl.suspend && state == hfo_pkg::HFO_RUN;
  endproperty
  a_wake_resume: assert property (p_wake_resume) else $error("Wake did not resume");

  property p_sync_busy;
    wake_hit && !wake_timer_s |=> sync_cnt == 2'h3;
  endproperty
  a_sync_busy: assert property (p_sync_busy) else $error("Sync busy not raised");

  property p_ss_follow;
    wr && paddr == hfo_pkg::ADDR_OSC_CTRL |=> spread_spectrum_enable == $past(pwdata[3]);
  endproperty
  a_ss_follow: assert property (p_ss_follow) else $error("Spread spectrum mismatch");

  property p_unused_zero;
    pready && !pwrite && paddr == hfo_pkg::ADDR_OSC_CTRL |-> prdata[2] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("Unused bit read one");

  property p_xtal_pins;
    ext_mode[2:1] == 2'b11 |-> pin_claim.crystal_input_claim && pin_claim.crystal_output_claim;
  endproperty
  a_xtal_pins: assert property (p_xtal_pins) else $error("Crystal pins not claimed");

  property p_other_pins;
    ext_mode[2:1] != 2'b11 |-> !pin_claim.crystal_input_claim
      && pin_claim.crystal_output_claim == (ext_mode[2:1] != 2'b00);
  endproperty
  a_other_pins: assert property (p_other_pins) else $error("Wrong pin claim");

  property p_apb_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB ready timing wrong");

  c_wake_foreign: cover property (wake_hit && !wake_timer_s);
  c_sync_done: cover property (sync_cnt == 2'h1 && tick);
  c_irq: cover property ($rose(irq));
  c_xtal: cover property (pin_claim.crystal_input_claim);

endmodule : hfo_control

// ---- bench/hfo_osc_model.sv ----
// Model of the oscillator, wake sources and wake timer clock at the block's pins.
// Assumes the bench raises wake requests on pclk and watches hf_osc_run.
`timescale 1ns/1ps
module hfo_osc_model #(
  parameter int SETTLE     = 4,
  parameter int TIMER_HALF = 8
) (
  // Clock
  input  wire logic pclk,
  // From the block and the bench
  input  wire logic hf_osc_run,
  input  wire logic wake_req,
  input  wire logic timer_wake_req,
  // Pins toward the block
  output logic      osc_at_freq,
  output logic      wake_event,
  output logic      wake_by_timer,
  output logic      timer_clk
);
  int settle_cnt;
  int timer_cnt;

  initial begin
    osc_at_freq   = 1'b0;
    wake_event    = 1'b0;
    wake_by_timer = 1'b0;
    timer_clk     = 1'b0;
    settle_cnt    = 0;
    timer_cnt     = 0;
  end

  // Lock only some cycles after start, drop at once on stop
  always @(posedge pclk) begin
    if (!hf_osc_run)
      settle_cnt <= 0;
    else if (settle_cnt < SETTLE)
      settle_cnt <= settle_cnt + 1;
    osc_at_freq <= hf_osc_run && (settle_cnt == SETTLE);
    timer_cnt   <= (timer_cnt == TIMER_HALF - 1) ? 0 : timer_cnt + 1;
    if (timer_cnt == TIMER_HALF - 1)
      timer_clk <= ~timer_clk;
    wake_event    <= wake_req;
    wake_by_timer <= timer_wake_req;
  end
endmodule : hfo_osc_model

// ---- bench/hfo_control_tb.sv ----
// Self-checking bench for the oscillator control block.
// Assumes APB with zero wait states and the pin model beside the block.
`timescale 1ns/1ps
module hfo_control_tb;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               osc_at_freq;
  logic               wake_event;
  logic               wake_by_timer;
  logic               timer_clk;
  logic               hf_osc_run;
  logic               spread_spectrum_enable;
  logic               system_clock_en;
  hfo_pkg::hfo_pins_t pin_claim;
  logic               irq;
  logic               wake_req = 1'b0;
  logic               timer_wake_req = 1'b0;
  logic               last_err;
  logic [31:0]        rv;
  int                 miscompares = 0;
  int                 check_count = 0;
  int                 g;
  logic [7:0]         row_wr[4] = '{8'h8f, 8'h81, 8'h82, 8'h84};
  logic [7:0]         row_rd[4] = '{8'hcb, 8'hc1, 8'hc2, 8'hc0};
  int                 row_gap[4] = '{1, 4, 2, 8};

  hfo_control u_hfo_control (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_at_freq(osc_at_freq), .wake_event(wake_event),
    .wake_by_timer(wake_by_timer), .timer_clk(timer_clk), .hf_osc_run(hf_osc_run),
    .spread_spectrum_enable(spread_spectrum_enable), .system_clock_en(system_clock_en),
    .pin_claim(pin_claim), .irq(irq));

  hfo_osc_model u_hfo_osc_model (.pclk(pclk), .hf_osc_run(hf_osc_run), .wake_req(wake_req),
    .timer_wake_req(timer_wake_req), .osc_at_freq(osc_at_freq), .wake_event(wake_event),
    .wake_by_timer(wake_by_timer), .timer_clk(timer_clk));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task tally_and_finish;
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task timeout;
    miscompares++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : timeout

  // One APB transfer, then one idle cycle
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      timeout();
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb(1'b1, a, d, dummy);
  endtask : wr

  // Cycles up to the next divider pulse
  task gap(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (system_clock_en !== 1'b1 && n < 20);
    if (n >= 20)
      timeout();
  endtask : gap

  task wait_run;
    int n;
    n = 0;
    while (hf_osc_run !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40)
      timeout();
  endtask : wait_run

  task do_reset;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : do_reset

  initial begin
    repeat (100000) @(posedge pclk);
    timeout();
  end

  initial begin
    do_reset();
    apb(1'b0, hfo_pkg::ADDR_OSC_CTRL, 32'h0, rv);
    check(rv, 32'h000000c0);
    apb(1'b0, hfo_pkg::ADDR_IRQ_MASK, 32'h0, rv);
    check(rv, 32'h0);
    check({30'h0, pin_claim}, 32'h0);
    wr(hfo_pkg::ADDR_IRQ_STATUS, 32'h7);
    for (int i = 0; i < 4; i++) begin
      wr(hfo_pkg::ADDR_OSC_CTRL, {24'h0, row_wr[i]});
      apb(1'b0, hfo_pkg::ADDR_OSC_CTRL, 32'h0, rv);
      check(rv, {24'h0, row_rd[i]});
      check({31'h0, spread_spectrum_enable}, {31'h0, row_wr[i][3]});
      gap(g);
      gap(g);
      gap(g);
      check(g, row_gap[i]);
    end
    // Stop the oscillator: no clock pulses, ready falls
    wr(hfo_pkg::ADDR_OSC_CTRL, 32'h0);
    check({31'h0, hf_osc_run}, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b0, hfo_pkg::ADDR_OSC_CTRL, 32'h0, rv);
    check(rv, 32'h0);
    g = 0;
    repeat (16) begin
      @(posedge pclk);
      g += int'(system_clock_en === 1'b1);
    end
    check(g, 0);
    wr(hfo_pkg::ADDR_IRQ_MASK, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(hfo_pkg::ADDR_OSC_CTRL, 32'h80);
    repeat (12) @(posedge pclk);
    apb(1'b0, hfo_pkg::ADDR_IRQ_STATUS, 32'h0, rv);
    check(rv, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(hfo_pkg::ADDR_IRQ_STATUS, 32'h1);
    check({31'h0, irq}, 32'h0);
    // Suspend, then wake from a foreign source
    wr(hfo_pkg::ADDR_OSC_CTRL, 32'ha0);
    check({31'h0, hf_osc_run}, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b0, hfo_pkg::ADDR_OSC_CTRL, 32'h0, rv);
    check(rv, 32'ha0);
    wake_req <= 1'b1;
    wait_run();
    wake_req <= 1'b0;
    apb(1'b0, hfo_pkg::ADDR_OSC_CTRL, 32'h0, rv);
    check(rv & 32'h30, 32'h10);
    g = 0;
    // Software leaves the wake timer alone until the flag clears
    do begin
      apb(1'b0, hfo_pkg::ADDR_OSC_CTRL, 32'h0, rv);
      g++;
    end while (rv[4] !== 1'b0 && g < 22);
    check({31'h0, rv[4]}, 32'h0);
    repeat (10) @(posedge pclk);
    apb(1'b0, hfo_pkg::ADDR_IRQ_STATUS, 32'h0, rv);
    check(rv, 32'h7);
    // Wake from the timer itself: no busy flag
    wr(hfo_pkg::ADDR_IRQ_STATUS, 32'h7);
    wr(hfo_pkg::ADDR_OSC_CTRL, 32'ha0);
    repeat (8) @(posedge pclk);
    timer_wake_req <= 1'b1;
    wait_run();
    timer_wake_req <= 1'b0;
    apb(1'b0, hfo_pkg::ADDR_OSC_CTRL, 32'h0, rv);
    check(rv & 32'h30, 32'h0);
    apb(1'b0, hfo_pkg::ADDR_IRQ_STATUS, 32'h0, rv);
    check(rv & 32'h2, 32'h2);
    // External modes; port setup for claimed pins is software's part
    for (int m = 0; m < 8; m++) begin
      wr(hfo_pkg::ADDR_EXT_OSC, 32'(m) << 4);
      check({30'h0, pin_claim}, (m >= 6) ? 32'h3 : (m >= 2) ? 32'h1 : 32'h0);
      apb(1'b0, hfo_pkg::ADDR_EXT_OSC, 32'h0, rv);
      check(rv, 32'(m) << 4);
    end
    apb(1'b0, 12'h000, 32'h0, rv);
    check({31'h0, last_err}, 32'h1);
    check(rv, 32'h0);
    // Reset in mid-run restores reset values
    wr(hfo_pkg::ADDR_OSC_CTRL, 32'h8b);
    do_reset();
    apb(1'b0, hfo_pkg::ADDR_OSC_CTRL, 32'h0, rv);
    check(rv, 32'h000000c0);
    check({30'h0, pin_claim}, 32'h0);
    check({31'h0, spread_spectrum_enable}, 32'h0);
    tally_and_finish();
  end
endmodule : hfo_control_tb
